// >>> design/socket_clk_pkg.sv
// Functional notes
// - Socket signals other than control pins are sampled on the card clock rise.
// - Card clock runs at half the host bus clock rate when running full speed.
// - Card clock may slow or stop; a stopped clock sits low.
// - Before slowing or stopping, clock-run is driven high for one clock, then released, to announce the decrease.
// - During socket reset the controller drives socket lines to valid levels.
// - Reset asserts at any time, but releases only on a card clock rise.
// - Address and data share one bus driven by the phase owner.
// - Address phase carries a 32-bit address, data phase data, bit 31 MSB.
package socket_clk_pkg;
    localparam int SYS_CLK_PERIOD_NS   = 20;
    localparam int CCLK_FULL_PERIOD_NS = 40;
    localparam int CCLK_SLOW_PERIOD_NS = 640;
    localparam int FULL_HALF_CYCLES    = CCLK_FULL_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
    localparam int SLOW_HALF_CYCLES    = CCLK_SLOW_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
    localparam int DIV_W               = 5;
    localparam logic [DIV_W-1:0] FULL_RELOAD = DIV_W'(FULL_HALF_CYCLES - 1);
    localparam logic [DIV_W-1:0] SLOW_RELOAD = DIV_W'(SLOW_HALF_CYCLES - 1);
    localparam logic [2:0] ANNOUNCE_LAST = 3'h3;
    localparam int NUM_SOCKETS = 2;
    localparam int BUS_W       = 32;

    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_SLOW = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_ANNOUNCE,
        ST_SLOW,
        ST_STOP
    } clk_state_t;

    typedef struct packed {
        logic [1:0]       mode;
        logic             reset_req;
        logic             drive_en;
        logic [BUS_W-1:0] drive_data;
        logic             addr_phase;
    } sock_req_t;

    typedef struct packed {
        clk_state_t       clk_state;
        logic             reset_active;
        logic             sample_valid;
        logic             sample_addr;
        logic [BUS_W-1:0] sample_data;
    } sock_status_t;

    typedef struct packed {
        logic             clkrun_in;
        logic [BUS_W-1:0] cad_in;
    } sock_pins_in_t;

    typedef struct packed {
        logic             cclk;
        logic             clkrun_out;
        logic             clkrun_oe;
        logic             crst_n;
        logic [BUS_W-1:0] cad_out;
        logic             cad_oe;
    } sock_pins_out_t;

    typedef struct packed {
        clk_state_t       st;
        logic [DIV_W-1:0] div;
        logic [2:0]       edges;
        logic             cclk;
        logic             clkrun_out;
        logic             clkrun_oe;
        logic             crst_n;
        logic [BUS_W-1:0] cad_out;
        logic             cad_oe;
        logic             smp_valid;
        logic             smp_addr;
        logic [BUS_W-1:0] smp_data;
    } sock_state_t;

    localparam sock_state_t SOCK_RST = '{
        st:         ST_RUN,
        div:        '0,
        edges:      3'h0,
        cclk:       1'b0,
        clkrun_out: 1'b0,
        clkrun_oe:  1'b1,
        crst_n:     1'b0,
        cad_out:    32'h0000_0000,
        cad_oe:     1'b1,
        smp_valid:  1'b0,
        smp_addr:   1'b0,
        smp_data:   32'h0000_0000
    };
endpackage

// >>> design/sync2.sv
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// >>> design/socket_clock_reset.sv
`timescale 1ns/100ps
module socket_clock_reset (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  socket_clk_pkg::sock_req_t      [1:0] req,
    output socket_clk_pkg::sock_status_t   [1:0] status,
    input  socket_clk_pkg::sock_pins_in_t  [1:0] pins_in,
    output socket_clk_pkg::sock_pins_out_t [1:0] pins_out
);
    genvar g;

    generate
        for (g = 0; g < socket_clk_pkg::NUM_SOCKETS; g++) begin : g_sock
            socket_clk_pkg::sock_state_t   s;
            socket_clk_pkg::sock_state_t   next_s;
            socket_clk_pkg::sock_pins_in_t pin_sync;
            logic                          rise;
            logic                          fall;
            logic                          runs;
            logic [socket_clk_pkg::DIV_W-1:0] reload;

            sync2 #(
                .W($bits(socket_clk_pkg::sock_pins_in_t))
            ) u_sync (
                .sys_clk(sys_clk),
                .rst_n  (rst_n),
                .d      (pins_in[g]),
                .q      (pin_sync)
            );

            always_comb begin
                next_s           = s;
                next_s.smp_valid = 1'b0;
                rise             = 1'b0;
                fall             = 1'b0;
                // Stopped clock finishes its high half, then parks low
                runs = (s.st != socket_clk_pkg::ST_STOP) || s.cclk;
                reload = (s.st == socket_clk_pkg::ST_SLOW || s.st == socket_clk_pkg::ST_STOP)
                       ? socket_clk_pkg::SLOW_RELOAD : socket_clk_pkg::FULL_RELOAD;
                if (runs) begin
                    if (s.div == '0) begin
                        next_s.cclk = ~s.cclk;
                        next_s.div  = reload;
                        rise        = ~s.cclk;
                        fall        = s.cclk;
                    end else begin
                        next_s.div = s.div - 1'b1;
                    end
                end

                if (req[g].reset_req) begin
                    // Assert at once, whatever the card clock is doing
                    next_s.crst_n     = 1'b0;
                    next_s.cad_oe     = 1'b1;
                    next_s.cad_out    = 32'h0000_0000;
                    next_s.clkrun_oe  = 1'b1;
                    next_s.clkrun_out = 1'b0;
                    next_s.st         = socket_clk_pkg::ST_RUN;
                    next_s.edges      = 3'h0;
                end else if (!s.crst_n) begin
                    // Release lines up with the card clock rise
                    if (rise) begin
                        next_s.crst_n = 1'b1;
                    end
                end else begin
                    if (rise) begin
                        next_s.smp_valid = 1'b1;
                        next_s.smp_addr  = req[g].addr_phase;
                        next_s.smp_data  = pin_sync.cad_in;
                    end
                    if (fall) begin
                        // Drive changes away from the sampling edge
                        next_s.cad_oe  = req[g].drive_en;
                        next_s.cad_out = req[g].drive_data;
                    end
                    case (s.st)
                        socket_clk_pkg::ST_RUN: begin
                            next_s.clkrun_oe  = 1'b1;
                            next_s.clkrun_out = 1'b0;
                            if (req[g].mode != socket_clk_pkg::MODE_FULL && rise) begin
                                // Drive high for one clock, then release
                                next_s.st         = socket_clk_pkg::ST_ANNOUNCE;
                                next_s.clkrun_out = 1'b1;
                                next_s.edges      = 3'h0;
                            end
                        end
                        socket_clk_pkg::ST_ANNOUNCE: begin
                            if (rise) begin
                                next_s.clkrun_oe = 1'b0;
                                next_s.edges     = s.edges + 3'h1;
                                if (!s.clkrun_oe && !pin_sync.clkrun_in) begin
                                    next_s.st         = socket_clk_pkg::ST_RUN;
                                    next_s.clkrun_oe  = 1'b1;
                                    next_s.clkrun_out = 1'b0;
                                end else if (s.edges == socket_clk_pkg::ANNOUNCE_LAST) begin
                                    case (req[g].mode)
                                        socket_clk_pkg::MODE_SLOW: begin
                                            next_s.st = socket_clk_pkg::ST_SLOW;
                                        end
                                        socket_clk_pkg::MODE_STOP: begin
                                            next_s.st = socket_clk_pkg::ST_STOP;
                                        end
                                        default: begin
                                            next_s.st         = socket_clk_pkg::ST_RUN;
                                            next_s.clkrun_oe  = 1'b1;
                                            next_s.clkrun_out = 1'b0;
                                        end
                                    endcase
                                end
                            end
                        end
                        socket_clk_pkg::ST_SLOW, socket_clk_pkg::ST_STOP: begin
                            next_s.clkrun_oe = 1'b0;
                            if (!pin_sync.clkrun_in
                                || req[g].mode == socket_clk_pkg::MODE_FULL) begin
                                next_s.st         = socket_clk_pkg::ST_RUN;
                                next_s.clkrun_oe  = 1'b1;
                                next_s.clkrun_out = 1'b0;
                                next_s.div        = '0;
                            end else if (s.st == socket_clk_pkg::ST_SLOW
                                         && req[g].mode == socket_clk_pkg::MODE_STOP
                                         && rise) begin
                                next_s.st         = socket_clk_pkg::ST_ANNOUNCE;
                                next_s.clkrun_oe  = 1'b1;
                                next_s.clkrun_out = 1'b1;
                                next_s.edges      = 3'h0;
                            end else if (s.st == socket_clk_pkg::ST_STOP
                                         && req[g].mode == socket_clk_pkg::MODE_SLOW) begin
                                next_s.st  = socket_clk_pkg::ST_SLOW;
                                next_s.div = '0;
                            end
                        end
                        default: begin
                            next_s.st = socket_clk_pkg::ST_RUN;
                        end
                    endcase
                end
            end

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s <= socket_clk_pkg::SOCK_RST;
                end else begin
                    s <= next_s;
                end
            end

            assign pins_out[g].cclk         = s.cclk;
            assign pins_out[g].clkrun_out   = s.clkrun_out;
            assign pins_out[g].clkrun_oe    = s.clkrun_oe;
            assign pins_out[g].crst_n       = s.crst_n;
            assign pins_out[g].cad_out      = s.cad_out;
            assign pins_out[g].cad_oe       = s.cad_oe;
            assign status[g].clk_state      = s.st;
            assign status[g].reset_active   = ~s.crst_n;
            assign status[g].sample_valid   = s.smp_valid;
            assign status[g].sample_addr    = s.smp_addr;
            assign status[g].sample_data    = s.smp_data;
        end
    endgenerate
endmodule

// >>> testbench/socket_clock_reset_chk.sv
`timescale 1ns/100ps
module socket_clock_reset_chk (
    input  wire logic                            sys_clk,
    input  wire logic                            rst_n,
    input  socket_clk_pkg::sock_req_t      [1:0] req,
    input  socket_clk_pkg::sock_status_t   [1:0] status,
    input  socket_clk_pkg::sock_pins_in_t  [1:0] pins_in,
    input  socket_clk_pkg::sock_pins_out_t [1:0] pins_out
);
    logic [1:0]                     st;
    socket_clk_pkg::sock_pins_out_t po;
    assign st = status[0].clk_state;
    assign po = pins_out[0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_reset_bus_valid: assert property (!po.crst_n |-> po.cad_oe && po.cad_out == '0)
        else $error("bus floats in reset");
    a_release_on_rise: assert property ($rose(po.crst_n) |-> $rose(po.cclk))
        else $error("reset released off a clock rise");
    a_full_rate: assert property ((st == 2'h0) [*8] |-> $changed(po.cclk))
        else $error("card clock not at full rate");
    a_stop_low: assert property ((st == 2'h3) [*3] |-> !po.cclk)
        else $error("stopped clock not low");
    a_no_silent_drop: assert property (st == 2'h0 |=> st inside {2'h0, 2'h1})
        else $error("decrease without announce");
    a_announce_high: assert property (st == 2'h1 && $past(st) == 2'h0 |-> po.clkrun_oe && po.clkrun_out)
        else $error("announce not driven");
    a_card_wake: assert property ((st[1] && !pins_in[0].clkrun_in) [*3] |-> ##[0:3] st == 2'h0)
        else $error("card request ignored");
    a_sample_on_rise: assert property (status[0].sample_valid |-> $rose(po.cclk))
        else $error("sample off a clock rise");
    a_bus_still_rise: assert property ($rose(po.cclk) && po.crst_n |-> $stable(po.cad_out) && $stable(po.cad_oe))
        else $error("bus moved at a rise");
    c_slow: cover property (st == 2'h2);
    c_stop: cover property (st == 2'h3);
    c_release: cover property ($rose(po.crst_n));
endmodule

// >>> testbench/card_model.sv
`timescale 1ns/100ps
module card_model (
    input  socket_clk_pkg::sock_pins_out_t po,
    input  wire logic                      want_fast,
    input  wire logic                      drive,
    input  wire logic [31:0]               data,
    output socket_clk_pkg::sock_pins_in_t  pi
);
    logic [31:0] last;
    always @(posedge po.cclk or negedge po.crst_n)
        if (!po.crst_n) last <= 32'h0000_0000;
        else last <= pi.cad_in;
    assign pi.clkrun_in = po.clkrun_oe ? po.clkrun_out : !want_fast;
    assign pi.cad_in = po.cad_oe ? po.cad_out : (drive && po.crst_n) ? data : ~last;
endmodule

// >>> testbench/socket_clock_reset_tb.sv
`timescale 1ns/100ps
module socket_clock_reset_tb;
    logic                           sys_clk = 1'b0;
    logic                           rst_n = 1'b0;
    socket_clk_pkg::sock_req_t      [1:0] req;
    socket_clk_pkg::sock_status_t   [1:0] status;
    socket_clk_pkg::sock_pins_in_t  [1:0] pins_in;
    socket_clk_pkg::sock_pins_out_t [1:0] pins_out;
    logic [1:0]                     want_fast = 2'h0;
    logic [1:0]                     drive = 2'h3;
    logic [31:0]                    data = 32'h0000_0000;
    logic [31:0]                    seed = 32'h0000_0009;
    int                             mismatches = 0;
    int                             comparisons = 0;
    always #10 sys_clk = ~sys_clk;
    socket_clock_reset u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .status(status),
        .pins_in(pins_in), .pins_out(pins_out));
    for (genvar g = 0; g < 2; g++) begin : g_card
        card_model u_card (.po(pins_out[g]), .want_fast(want_fast[g]), .drive(drive[g]),
            .data(data), .pi(pins_in[g]));
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int exp_rises(int cyc, int half);
        return cyc / (2 * half);
    endfunction
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_st(logic [1:0] s, int lim);
        int n;
        n = 0;
        while (status[0].clk_state !== s && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        chk("clk_state", status[0].clk_state, s);
        if (status[0].clk_state !== s) final_report();
    endtask
    task automatic rises(int g, int cyc, output int n);
        logic prev;
        n = 0;
        @(negedge sys_clk);
        prev = pins_out[g].cclk;
        repeat (cyc) begin
            @(negedge sys_clk);
            n += int'(pins_out[g].cclk && !prev);
            prev = pins_out[g].cclk;
        end
    endtask
    initial begin
        int n;
        logic [31:0] v;
        req = '0;
        repeat (5) @(posedge sys_clk);
        chk("crst_n in reset", pins_out[0].crst_n, 0);
        rst_n <= 1'b1;
        rises(0, 20, n);
        chk("full rate rises", n, exp_rises(20, socket_clk_pkg::FULL_HALF_CYCLES));
        chk("crst_n released", pins_out[0].crst_n, 1);
        v = rnd();
        @(posedge sys_clk);
        req[0].drive_en <= 1'b1;
        req[0].drive_data <= v;
        repeat (6) @(negedge sys_clk);
        chk("cad_out", pins_out[0].cad_out, v);
        chk("cad_oe", pins_out[0].cad_oe, 1);
        @(posedge sys_clk);
        req[0].drive_en <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            @(posedge sys_clk);
            data <= v;
            req[0].addr_phase <= i[0];
            repeat (8) @(negedge sys_clk);
            n = 0;
            while (status[0].sample_valid !== 1'b1 && n < 8) begin
                @(negedge sys_clk);
                n++;
            end
            chk("sample_valid", status[0].sample_valid, 1);
            if (status[0].sample_valid !== 1'b1) final_report();
            chk("sample_data", status[0].sample_data, v);
            chk("sample_addr", status[0].sample_addr, i[0]);
        end
        for (int m = 1; m < 3; m++) begin
            @(posedge sys_clk);
            req[0].mode <= 2'(m);
            wait_st(socket_clk_pkg::ST_ANNOUNCE, 8);
            chk("announce", {pins_out[0].clkrun_oe, pins_out[0].clkrun_out}, 2'h3);
            wait_st(2'(m + 1), 12);
            rises(0, 128, n);
            chk("slowed rises", n,
                m == 1 ? exp_rises(128, socket_clk_pkg::SLOW_HALF_CYCLES) : 0);
            rises(1, 20, n);
            chk("other socket rises", n, exp_rises(20, socket_clk_pkg::FULL_HALF_CYCLES));
            if (m == 1) begin
                @(posedge sys_clk);
                req[0].mode <= 2'h0;
                wait_st(socket_clk_pkg::ST_RUN, 4);
            end
        end
        chk("stopped level", pins_out[0].cclk, 0);
        @(posedge sys_clk);
        req[0].mode <= socket_clk_pkg::MODE_SLOW;
        wait_st(socket_clk_pkg::ST_SLOW, 4);
        @(posedge sys_clk);
        req[0].mode <= socket_clk_pkg::MODE_STOP;
        wait_st(socket_clk_pkg::ST_ANNOUNCE, 40);
        chk("re-announce", {pins_out[0].clkrun_oe, pins_out[0].clkrun_out}, 2'h3);
        wait_st(socket_clk_pkg::ST_STOP, 40);
        @(posedge sys_clk);
        want_fast <= 2'h1;
        wait_st(socket_clk_pkg::ST_RUN, 6);
        n = 0;
        repeat (64) begin
            @(negedge sys_clk);
            n += int'(status[0].clk_state == socket_clk_pkg::ST_STOP);
        end
        chk("refused cycles", n, 0);
        @(posedge sys_clk);
        {want_fast, req[0].mode, req[0].reset_req} <= {2'h0, 2'h0, 1'b1};
        repeat (2) @(negedge sys_clk);
        chk("reset crst_n", pins_out[0].crst_n, 0);
        chk("reset cad_oe", pins_out[0].cad_oe, 1);
        chk("reset cad_out", pins_out[0].cad_out, 32'h0000_0000);
        chk("reset_active", status[0].reset_active, 1);
        chk("other socket reset", pins_out[1].crst_n, 1);
        @(posedge sys_clk);
        req[0].reset_req <= 1'b0;
        n = 0;
        while (pins_out[0].crst_n !== 1'b1 && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        chk("crst_n released again", pins_out[0].crst_n, 1);
        if (pins_out[0].crst_n !== 1'b1) final_report();
        chk("release on rise", pins_out[0].cclk, 1);
        final_report();
    end
endmodule
bind socket_clock_reset socket_clock_reset_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .req(req), .status(status), .pins_in(pins_in), .pins_out(pins_out));
